// >>> logic/battery_switchover_watchdog.sv
// Purpose: supply source selection and watchdog with AXI4-Lite registers
// Assumes: comparator flags are synchronous to aclk
// Notes: analog switching is outside; this logic only decides
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module battery_switchover_watchdog #(
    parameter int unsigned timeout_cycles = switchover_pkg::timeout_cycles,
    parameter int unsigned self_kick_cycles = switchover_pkg::self_kick_cycles
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Comparator flags
    input wire logic main_above_battery,
    input wire logic main_above_switch_threshold,
    input wire logic output_below_switch_threshold_falling,
    input wire logic main_above_switch_threshold_rising,
    // Manual select and kick
    input wire logic manual_backup_select,
    input wire logic kick,
    input wire logic kick_floating,
    // Outputs
    output logic battery_on_indicator,
    output logic supervisor_reset_n,
    output logic watchdog_kick_drive,
    output logic irq,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import switchover_pkg::*;

    source_type source_reg;
    source_type source_next;
    logic [1:0] ctrl_reg;
    logic [2:0] mask_reg;
    logic [2:0] irq_reg;
    logic [2:0] irq_events;
    logic [3:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_held_reg;
    logic timeout_pulse;
    logic internal_kick;
    logic wd_reset_reg;
    logic on_batt;
    logic go_batt;
    logic go_main;
    logic force_batt;
    logic wd_enable;
    logic do_write;
    logic do_read;
    logic irq_read;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic [31:0] rd_value;
    logic rd_mapped;
    logic wr_mapped;

    // Watchdog core; a software disable bit parks it as if the kick were floating
    kick_watchdog #(
        .timeout_cycles(timeout_cycles),
        .self_kick_cycles(self_kick_cycles)
    ) u_wdt (
        .aclk(aclk),
        .aresetn(aresetn),
        .kick(kick),
        .kick_floating(kick_floating || !wd_enable),
        .timeout_pulse(timeout_pulse),
        .internal_kick(internal_kick)
    );

    // ctrl bit 0: software manual backup request, bit 1: watchdog disable
    assign wd_enable = !ctrl_reg[1];
    assign on_batt = (source_reg == src_batt);
    assign force_batt = manual_backup_select || ctrl_reg[0];
    // Comparator pair must both say main is weak; output droop is the trigger
    assign go_batt = !main_above_battery && !main_above_switch_threshold
        && output_below_switch_threshold_falling;
    // Return waits for main to cross battery or rise past the rising threshold
    assign go_main = main_above_battery || main_above_switch_threshold_rising;
    always_comb begin
        source_next = source_reg;
        unique case (source_reg)
            src_main: begin
                if (go_batt || (force_batt && !main_above_battery && !main_above_switch_threshold)) begin
                    source_next = src_batt;
                end else if (force_batt) begin
                    source_next = src_batt;
                end
            end
            src_batt: begin
                // Manual select holds battery here; otherwise the supply comparators decide
                if (go_main && !force_batt) begin
                    source_next = src_main;
                end
            end
            default: source_next = src_main;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            source_reg <= src_main;
        end else begin
            source_reg <= source_next;
        end
    end

    assign battery_on_indicator = on_batt;
    assign watchdog_kick_drive = internal_kick;

    // One-cycle reset pulse per timeout; watchdog already restarted by then
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_reset_reg <= 1'b0;
        end else begin
            wd_reset_reg <= timeout_pulse;
        end
    end
    assign supervisor_reset_n = !wd_reset_reg;

    // AXI4-Lite slave: address and data may arrive in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
    assign do_write = (aw_held_reg || (s_axi_awvalid && s_axi_awready))
        && (w_held_reg || (s_axi_wvalid && s_axi_wready));
    assign wr_mapped = (wr_addr == addr_ctrl) || (wr_addr == addr_mask);
    assign s_axi_arready = !s_axi_rvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;
    assign rd_mapped = (s_axi_araddr == addr_ctrl) || (s_axi_araddr == addr_status)
        || (s_axi_araddr == addr_irq) || (s_axi_araddr == addr_mask);
    // Status word: bit 0 on battery, bit 1 manual force, bit 2 reset output
    assign rd_value = (s_axi_araddr == addr_ctrl) ? {30'h0, ctrl_reg}
        : (s_axi_araddr == addr_status) ? {29'h0, supervisor_reset_n, force_batt, on_batt}
        : (s_axi_araddr == addr_irq) ? {29'h0, irq_reg}
        : (s_axi_araddr == addr_mask) ? {29'h0, mask_reg} : 32'h0;
    assign irq_read = do_read && (s_axi_araddr == addr_irq);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
        end else begin
            if (s_axi_awvalid && s_axi_awready && !do_write) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready && !do_write) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? resp_okay : resp_slverr;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Only the low byte holds live bits, so lane 0 alone gates a write
    logic wr_lane0;
    assign wr_lane0 = w_held_reg ? wstrb_reg[0] : s_axi_wstrb[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= ctrl_reset_val;
            mask_reg <= mask_reset_val;
        end else if (do_write && wr_lane0) begin
            if (wr_addr == addr_ctrl) ctrl_reg <= wr_data[1:0];
            if (wr_addr == addr_mask) mask_reg <= wr_data[2:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= resp_okay;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_mapped ? resp_okay : resp_slverr;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Sticky events; a new event in the clearing read's cycle survives
    assign irq_events[irq_timeout_bit] = timeout_pulse;
    assign irq_events[irq_to_batt_bit] = (source_reg == src_main) && (source_next == src_batt);
    assign irq_events[irq_to_main_bit] = (source_reg == src_batt) && (source_next == src_main);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg <= 3'h0;
        end else begin
            irq_reg <= (irq_read ? 3'h0 : irq_reg) | irq_events;
        end
    end
    // Level output; a masked event stays recorded and shows once unmasked
    assign irq = |(irq_reg & mask_reg);

    // Source selection
    a_main_wins: assert property (@(posedge aclk) disable iff (!aresetn)
        (main_above_battery && !force_batt && on_batt) |=> !on_batt)
        else $error("battery kept while main above battery");
    a_auto_switch: assert property (@(posedge aclk) disable iff (!aresetn)
        (!on_batt && go_batt) |=> on_batt)
        else $error("no switch to battery on main failure");
    a_defer_return: assert property (@(posedge aclk) disable iff (!aresetn)
        (on_batt && !go_main) |=> on_batt)
        else $error("left battery before main recovered");
    a_flags_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (!on_batt && (main_above_battery || main_above_switch_threshold) && !force_batt) |=> !on_batt)
        else $error("battery chosen while a flag is true");
    a_manual_force: assert property (@(posedge aclk) disable iff (!aresetn)
        (!on_batt && manual_backup_select) |=> on_batt)
        else $error("manual select did not force battery");
    a_batt_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        (on_batt && manual_backup_select) |=> on_batt)
        else $error("manual select released battery mode");
    a_indicator_match: assert property (@(posedge aclk) disable iff (!aresetn)
        battery_on_indicator == (source_reg == src_batt))
        else $error("indicator disagrees with source");
    a_batt_event: assert property (@(posedge aclk) disable iff (!aresetn)
        (!on_batt && go_batt) |=> irq_reg[irq_to_batt_bit])
        else $error("switch to battery not recorded");

    // Watchdog reset pulse
    a_timeout_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        timeout_pulse |=> !supervisor_reset_n ##1 supervisor_reset_n)
        else $error("timeout did not pulse reset");
    a_reset_single: assert property (@(posedge aclk) disable iff (!aresetn)
        !supervisor_reset_n |=> supervisor_reset_n)
        else $error("reset pulse longer than one cycle");
    a_timeout_event: assert property (@(posedge aclk) disable iff (!aresetn)
        timeout_pulse |=> irq_reg[irq_timeout_bit])
        else $error("timeout not recorded");
    a_self_kick: assert property (@(posedge aclk) disable iff (!aresetn)
        internal_kick |=> !internal_kick)
        else $error("internal kick not a short pulse");

    // Register bus; a missing answer would leave the master waiting forever
    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        do_read |=> s_axi_rvalid)
        else $error("read not answered");
    a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_read && !rd_mapped) |=> (s_axi_rresp == resp_slverr) && (s_axi_rdata == 32'h0))
        else $error("unmapped read not refused");
    a_ctrl_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_write && wr_lane0 && (wr_addr == addr_ctrl)) |=> (ctrl_reg == $past(wr_data[1:0])))
        else $error("control write lost");
    a_event_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        !irq_read |=> ((irq_reg & $past(irq_reg)) == $past(irq_reg)))
        else $error("event bit dropped without a read");

    c_to_batt: cover property (@(posedge aclk) disable iff (!aresetn) irq_events[irq_to_batt_bit]);
    c_to_main: cover property (@(posedge aclk) disable iff (!aresetn) irq_events[irq_to_main_bit]);
    c_timeout: cover property (@(posedge aclk) disable iff (!aresetn) timeout_pulse);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
    c_manual_hold: cover property (@(posedge aclk) disable iff (!aresetn) on_batt && manual_backup_select);
endmodule : battery_switchover_watchdog
`default_nettype wire

// >>> logic/kick_watchdog.sv
// Purpose: watchdog counter retriggered by edges on the kick input
// Assumes: kick input synchronous to aclk
// Notes: the floating case is modelled by the kick_floating input
`timescale 1ns/1ns
`default_nettype none
module kick_watchdog #(
    parameter int unsigned timeout_cycles = switchover_pkg::timeout_cycles,
    parameter int unsigned self_kick_cycles = switchover_pkg::self_kick_cycles
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Kick input
    input wire logic kick,
    input wire logic kick_floating,
    // Result
    output logic timeout_pulse,
    output logic internal_kick
);
    import switchover_pkg::*;
    logic [wdt_width-1:0] count_reg;
    logic [wdt_width-1:0] count_next;
    logic kick_prev_reg;
    logic edge_seen;
    logic expired;
    logic self_pulse;
    logic restart;
    // Floating input: internal drive is low, then a short high pulse at 7/8 restarts the timer
    // A count already past 7/8 when the kick floats pulses at once, so a late float never times out
    assign self_pulse = kick_floating && (count_reg >= wdt_width'(self_kick_cycles));
    assign internal_kick = self_pulse;
    assign edge_seen = !kick_floating && (kick != kick_prev_reg);
    assign expired = !kick_floating && (count_reg == wdt_width'(timeout_cycles - 1));
    assign restart = edge_seen || self_pulse || expired;
    assign count_next = restart ? '0 : count_reg + wdt_width'(1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= '0;
            kick_prev_reg <= 1'b0;
            timeout_pulse <= 1'b0;
        end else begin
            count_reg <= count_next;
            kick_prev_reg <= kick;
            timeout_pulse <= expired && !edge_seen;
        end
    end
    a_wdt_reset_clear: assert property (@(posedge aclk) !aresetn |=> count_reg == '0)
        else $error("watchdog not cleared in reset");
    a_edge_restart: assert property (@(posedge aclk) disable iff (!aresetn) edge_seen |=> count_reg == '0)
        else $error("kick edge did not restart watchdog");
    a_float_no_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
        kick_floating [*2] |-> !timeout_pulse && (count_reg <= wdt_width'(self_kick_cycles)))
        else $error("floating kick reached timeout");
endmodule : kick_watchdog
`default_nettype wire

// >>> logic/switchover_pkg.sv
// Purpose: constants for the battery switchover and watchdog block
// Assumes: 25 MHz clock on aclk
// Notes: register offsets are byte addresses on the AXI4-Lite slave
package switchover_pkg;
    localparam int unsigned clk_hz = 25000000;
    localparam int unsigned timeout_ms = 800;
    localparam int unsigned timeout_cycles = (clk_hz / 1000) * timeout_ms;
    localparam int unsigned self_kick_num = 7;
    localparam int unsigned self_kick_den = 8;
    localparam int unsigned self_kick_cycles = (timeout_cycles / self_kick_den) * self_kick_num;
    localparam int unsigned wdt_width = 25;
    localparam logic [3:0] addr_ctrl = 4'h0;
    localparam logic [3:0] addr_status = 4'h4;
    localparam logic [3:0] addr_irq = 4'h8;
    localparam logic [3:0] addr_mask = 4'hC;
    localparam logic [1:0] ctrl_reset_val = 2'h0;
    localparam logic [2:0] mask_reset_val = 3'h0;
    localparam int unsigned irq_timeout_bit = 0;
    localparam int unsigned irq_to_batt_bit = 1;
    localparam int unsigned irq_to_main_bit = 2;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    typedef enum logic [1:0] {
        src_main = 2'b01,
        src_batt = 2'b10
    } source_type;
endpackage : switchover_pkg

// >>> tb/battery_switchover_watchdog_test.sv
// Purpose: self-checking bench for source selection, watchdog and registers
// Assumes: short watchdog counts of 64 and 56 cycles
// Notes: bus answers are queued by the driver and matched by a monitor
`timescale 1ns/1ns
`default_nettype none
module battery_switchover_watchdog_test;
    import switchover_pkg::*;
    localparam int unsigned to_cyc = 64;
    localparam int unsigned sk_cyc = 56;
    logic aclk, aresetn, main_above_battery, main_above_switch_threshold;
    logic output_below_switch_threshold_falling, main_above_switch_threshold_rising;
    logic manual_backup_select, kick, kick_floating, battery_on_indicator, supervisor_reset_n;
    logic watchdog_kick_drive, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic host_en, rst_ok;
    logic [5:0] host_gap;
    logic [31:0] seed;
    logic [1:0] wq[$];
    logic [33:0] rq[$];
    int n_errors, comparisons, c;
    battery_switchover_watchdog #(.timeout_cycles(to_cyc), .self_kick_cycles(sk_cyc)) uut (.aclk, .aresetn,
        .main_above_battery, .main_above_switch_threshold, .output_below_switch_threshold_falling,
        .main_above_switch_threshold_rising, .manual_backup_select, .kick, .kick_floating,
        .battery_on_indicator, .supervisor_reset_n, .watchdog_kick_drive, .irq, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    kick_host host (.aclk(aclk), .enable(host_en), .interval(host_gap), .kick(kick));
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        wq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(s_axi_bvalid && s_axi_bready) && n < 50) begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        if (n >= 50) check(34'h0, 34'h1);
        @(posedge aclk);
    endtask : bus_wr
    task automatic bus_rd(input logic [3:0] a, input logic [33:0] e);
        int n;
        n = 0;
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!(s_axi_rvalid && s_axi_rready) && n < 50) begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        if (n >= 50) check(34'h0, 34'h1);
        @(posedge aclk);
    endtask : bus_rd
    // Count edges until the kick pulse (sel) or the reset pulse appears
    task automatic gap(input logic sel, input int lo, input int hi);
        c = 0;
        while ((sel ? watchdog_kick_drive : !supervisor_reset_n) !== 1'b1 && c < 300) begin
            @(posedge aclk);
            c++;
        end
        check(c >= lo && c <= hi, 1'b1);
        @(posedge aclk);
    endtask : gap
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) check(s_axi_bresp, wq.pop_front());
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (aresetn && !rst_ok) check(supervisor_reset_n, 1'b1);
    end
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial begin
        #(40 * 40000);
        n_errors++;
        finish_test();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 32'h0, 4'hF};
        {main_above_battery, main_above_switch_threshold} = 2'h3;
        {output_below_switch_threshold_falling, main_above_switch_threshold_rising} = 2'h1;
        manual_backup_select = 1'b0;
        {kick_floating, rst_ok, host_en, host_gap, seed} = {3'h1, 6'h0A, 32'h01C9AC93};
        cyc(20);
        aresetn <= 1'b1;
        cyc(2);
        check({battery_on_indicator, irq}, 2'h0);
        bus_rd(addr_ctrl, 34'h0);
        bus_rd(addr_mask, 34'h0);
        bus_rd(addr_status, 34'h4);
        bus_rd(4'h2, {resp_slverr, 32'h0});
        bus_wr(addr_status, 32'h1, resp_slverr);
        bus_wr(addr_mask, 32'h7, resp_okay);
        output_below_switch_threshold_falling <= 1'b1;
        main_above_switch_threshold_rising <= 1'b0;
        for (int i = 3; i >= 0; i--) begin
            {main_above_battery, main_above_switch_threshold} <= i[1:0];
            cyc(3);
            check(battery_on_indicator, i == 0);
        end
        check(irq, 1'b1);
        bus_rd(addr_irq, 34'h2);
        output_below_switch_threshold_falling <= 1'b0;
        cyc(5);
        check({battery_on_indicator, irq}, 2'h2);
        main_above_battery <= 1'b1;
        cyc(3);
        check(battery_on_indicator, 1'b0);
        bus_rd(addr_irq, 34'h4);
        {main_above_switch_threshold, main_above_switch_threshold_rising} <= 2'h3;
        manual_backup_select <= 1'b1;
        cyc(3);
        check(battery_on_indicator, 1'b1);
        cyc(10);
        check(battery_on_indicator, 1'b1);
        manual_backup_select <= 1'b0;
        cyc(3);
        check(battery_on_indicator, 1'b0);
        bus_rd(addr_irq, 34'h6);
        host_gap <= 6'h04;
        bus_wr(addr_ctrl, 32'h3, resp_okay);
        check(battery_on_indicator, 1'b1);
        bus_rd(addr_status, 34'h7);
        bus_rd(addr_ctrl, 34'h3);
        bus_wr(addr_ctrl, 32'h0, resp_okay);
        check(battery_on_indicator, 1'b0);
        bus_rd(addr_irq, 34'h6);
        for (int i = 0; i < 10; i++) begin
            host_gap <= 6'(xs() % 40 + 1);
            cyc(32);
        end
        host_en <= 1'b0;
        kick_floating <= 1'b1;
        gap(1'b1, 0, sk_cyc + 8);
        gap(1'b1, sk_cyc - 2, sk_cyc + 4);
        cyc(200);
        rst_ok <= 1'b1;
        kick_floating <= 1'b0;
        aresetn <= 1'b0;
        cyc(100);
        check(supervisor_reset_n, 1'b1);
        aresetn <= 1'b1;
        gap(1'b0, to_cyc - 2, to_cyc + 6);
        check(supervisor_reset_n, 1'b1);
        gap(1'b0, to_cyc - 3, to_cyc + 6);
        host_en <= 1'b1;
        bus_wr(addr_mask, 32'h1, resp_okay);
        check(irq, 1'b1);
        bus_rd(addr_irq, 34'h1);
        cyc(2);
        check(irq, 1'b0);
        finish_test();
    end
endmodule : battery_switchover_watchdog_test
`default_nettype wire

// >>> tb/kick_host.sv
// Purpose: host model that pulses the watchdog kick input
// Assumes: one clock, pulses one cycle wide
// Notes: kick rests low between pulses to keep input current low
`timescale 1ns/1ns
`default_nettype none
module kick_host (
    // Clock
    input wire logic aclk,
    // Control
    input wire logic enable,
    input wire logic [5:0] interval,
    // Kick
    output logic kick
);
    logic [5:0] count_reg;
    initial kick = 1'b0;
    initial count_reg = 6'h00;
    always @(posedge aclk) begin
        if (!enable || count_reg >= interval) begin
            count_reg <= 6'h00;
        end else begin
            count_reg <= count_reg + 6'h01;
        end
        kick <= enable && count_reg >= interval;
    end
endmodule : kick_host
`default_nettype wire
